// File: rtl/lmcir_top.sv
/*
 * configuration, interrupt mask and trigger-frame registers of an led
 * dot-matrix driver, with the two-wire bus slave that reaches them, the
 * interrupt status flags and the open-drain interrupt pin.
 * assumes scl/sda arrive already synchronous to ref_clk and the event
 * inputs are one-cycle pulses except low_vdd_det, which is a level.
 * scl high and low phases must each last two ref_clk cycles or more,
 * since start, stop and bit edges come from comparing two samples.
 * a status read clears every flag, power-on included, so the pin lets
 * go even with the reset mask; the power-on flag shows once per reset.
 * the lock covers trim and layout only and needs data_wr pulsed on the
 * first write to any display data section.
 * the frame event is only as good as final_loop: a looping movie must
 * raise it on its last pass alone.
 */
// Summary of operation
// - with autoclear set, movie or picture end clears the supply-low flag
// - routing bit zero: supply-low sets status and fires the interrupt normally
// - routing bit one: pin follows supply-low flag; status still updates
// - open-led disable bit makes open leds found by testing disabled
// - broadcast bit makes the device also answer bus address 0111111
// - layout code 000 is invalid and the reset value; 001-110 pick layouts
// - layout and trim settings lock after first data write until reset
// - mask bit 7 gates the selected-frame event onto the pin
// - mask bit 6 gates the bus watchdog event onto the pin
// - mask bit 5 gates power-on reset event; mask resets to 0x20
// - mask bit 4 gates the over-temperature event onto the pin
// - mask bit 3 gates the supply-low event onto the pin
// - mask bit 2 gates the open-test error onto the pin
// - mask bit 1 gates the short-test error onto the pin
// - mask bit 0 gates the movie-finished event onto the pin
// - trigger frame field fires after its last showing; resets 111111
// - configuration register resets to 0x00
// - reading status clears it to 0x00 and, with routing bit zero, releases the pin
`timescale 1ns/1ps
`default_nettype none
`include "lmcir_regs.svh"

module lmcir_top #(
    parameter logic [3:0] BUS_ADDR_HI = 4'h6
) (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    // two-wire bus pins
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe_n,
    input  wire logic [2:0]         addr_sel,
    // interrupt pin, open drain
    output logic                    irq_out,
    output logic                    irq_oe_n,
    // device side
    input  wire lmcir_pkg::lmcir_evt_t evt,
    output lmcir_pkg::lmcir_cfg_t   cfg_out
);
    import lmcir_pkg::*;

    // ************************************************************************
    // reset image of the whole state
    // ************************************************************************
    localparam lmcir_core_t RST_S = '{
        st:       LMCIR_IDLE,
        ret:      LMCIR_IDLE,
        scl_q:    1'b1,
        sda_q:    1'b1,
        sh:       8'h00,
        cnt:      4'h0,
        nack:     1'b0,
        ptr:      8'h00,
        sda_oe_n: 1'b1,
        cfg:      `LMCIR_RST_CFG,
        mask:     `LMCIR_RST_MASK,
        frm:      `LMCIR_RST_FRM,
        stat:     `LMCIR_RST_STAT,
        low_vdd:  1'b0,
        locked:   1'b0,
        irq_low:  1'b1
    };

    // ************************************************************************
    // helpers
    // ************************************************************************
    function automatic logic [7:0] reg_read(
        input logic [7:0]  p,
        input lmcir_core_t c
    );
        logic [7:0] v;
        v = 8'h00;
        if (p == `LMCIR_OFS_CFG) begin
            v = c.cfg;
        end else if (p == `LMCIR_OFS_MASK) begin
            v = c.mask;
        end else if (p == `LMCIR_OFS_FRM) begin
            v = {2'b00, c.frm};
        end else if (p == `LMCIR_OFS_STAT) begin
            v = c.stat;
        end
        return v;
    endfunction

    // locked fields keep their old value; unmapped pointers read as zero
    function automatic logic [7:0] cfg_merge(
        input logic [7:0] old,
        input logic [7:0] wr,
        input logic       lock
    );
        logic [7:0] v;
        v = wr;
        if (lock) begin
            v = (wr & ~`LMCIR_CFG_LOCKED) | (old & `LMCIR_CFG_LOCKED);
        end
        return v;
    endfunction

    function automatic logic addr_hit(
        input logic [6:0] a,
        input logic [2:0] sel,
        input logic       bcast
    );
        logic hit;
        hit = (a == {BUS_ADDR_HI, sel});
        if (bcast && a == `LMCIR_BCAST_ADDR) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // read clear first, then this cycle's events, so a set is never lost
    function automatic logic [7:0] stat_next(
        input logic [7:0] old,
        input logic [7:0] evs,
        input logic       clr
    );
        logic [7:0] v;
        v = old;
        if (clr) begin
            v = `LMCIR_STAT_CLR;
        end
        return v | evs;
    endfunction

    // direct mode hands the supply flag to the pin and drops all gating
    function automatic logic irq_level(
        input logic [7:0] st,
        input logic [7:0] mk,
        input logic       direct,
        input logic       lowv
    );
        logic v;
        v = |(st & mk);
        if (direct) begin
            v = lowv;
        end
        return v;
    endfunction

    // ************************************************************************
    // state
    // ************************************************************************
    lmcir_core_t s;
    lmcir_core_t next_s;
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic        do_load;
    logic [7:0]  rd_byte;
    logic [7:0]  ev_set;
    logic        frame_hit;

    assign rise  = scl_in & ~s.scl_q;
    assign fall  = ~scl_in & s.scl_q;
    assign start = s.scl_q & scl_in & s.sda_q & ~sda_in;
    assign stop  = s.scl_q & scl_in & ~s.sda_q & sda_in;
    assign rd_byte = reg_read(s.ptr, s);

    // the frame event waits for the final loop so a looping movie
    // interrupts once, not on every pass
    assign frame_hit = evt.frame_done & evt.final_loop
                     & (evt.frame_num == s.frm);

    always_comb begin
        ev_set = 8'h00;
        ev_set[`LMCIR_EV_FRAME] = frame_hit;
        ev_set[`LMCIR_EV_WDOG]  = evt.wdog;
        ev_set[`LMCIR_EV_TEMP]  = evt.overtemp;
        ev_set[`LMCIR_EV_LOWV]  = evt.low_vdd_det;
        ev_set[`LMCIR_EV_OPEN]  = evt.open_err;
        ev_set[`LMCIR_EV_SHORT] = evt.short_err;
        ev_set[`LMCIR_EV_MOVIE] = evt.movie_fin;
    end

    // ************************************************************************
    // next state
    // ************************************************************************
    always_comb begin
        next_s = s;
        do_load = 1'b0;
        next_s.scl_q = scl_in;
        next_s.sda_q = sda_in;

        // bus slave
        if (start) begin
            next_s.st = LMCIR_ADDR;
            next_s.cnt = 4'h0;
            next_s.sda_oe_n = 1'b1;
        end else if (stop) begin
            next_s.st = LMCIR_IDLE;
            next_s.sda_oe_n = 1'b1;
        end else if (rise) begin
            if (s.st == LMCIR_ACKM) begin
                next_s.nack = sda_in;
            end else if (s.st != LMCIR_IDLE && s.st != LMCIR_ACKS) begin
                // in a read this also moves the next outgoing bit to the top
                next_s.sh = {s.sh[6:0], sda_in};
                next_s.cnt = s.cnt + 4'h1;
            end
        end else if (fall) begin
            case (s.st)
                LMCIR_ADDR: begin
                    if (s.cnt == `LMCIR_BIT_LAST) begin
                        if (addr_hit(s.sh[7:1], addr_sel, s.cfg[`LMCIR_CFG_BCAST])) begin
                            next_s.st = LMCIR_ACKS;
                            next_s.ret = s.sh[0] ? LMCIR_RD : LMCIR_PTR;
                            next_s.sda_oe_n = 1'b0;
                        end else begin
                            next_s.st = LMCIR_IDLE;
                        end
                    end
                end
                LMCIR_PTR: begin
                    if (s.cnt == `LMCIR_BIT_LAST) begin
                        next_s.ptr = s.sh;
                        next_s.st = LMCIR_ACKS;
                        next_s.ret = LMCIR_WR;
                        next_s.sda_oe_n = 1'b0;
                    end
                end
                LMCIR_WR: begin
                    if (s.cnt == `LMCIR_BIT_LAST) begin
                        if (s.ptr == `LMCIR_OFS_CFG) begin
                            next_s.cfg = cfg_merge(s.cfg, s.sh, s.locked);
                        end else if (s.ptr == `LMCIR_OFS_MASK) begin
                            next_s.mask = s.sh;
                        end else if (s.ptr == `LMCIR_OFS_FRM) begin
                            next_s.frm = s.sh[5:0];
                        end
                        next_s.ptr = s.ptr + 8'h01;
                        next_s.st = LMCIR_ACKS;
                        next_s.ret = LMCIR_WR;
                        next_s.sda_oe_n = 1'b0;
                    end
                end
                LMCIR_RD: begin
                    if (s.cnt == `LMCIR_BIT_LAST) begin
                        next_s.sda_oe_n = 1'b1;
                        next_s.st = LMCIR_ACKM;
                    end else begin
                        next_s.sda_oe_n = s.sh[7];
                    end
                end
                LMCIR_ACKS: begin
                    next_s.sda_oe_n = 1'b1;
                    next_s.cnt = 4'h0;
                    next_s.st = s.ret;
                    do_load = (s.ret == LMCIR_RD);
                end
                LMCIR_ACKM: begin
                    next_s.cnt = 4'h0;
                    if (s.nack) begin
                        next_s.st = LMCIR_IDLE;
                    end else begin
                        next_s.st = LMCIR_RD;
                        do_load = 1'b1;
                    end
                end
                default: begin
                    next_s.st = LMCIR_IDLE;
                end
            endcase
        end

        // first read bit goes out on the same falling edge as the load
        if (do_load) begin
            next_s.sh = rd_byte;
            next_s.sda_oe_n = rd_byte[7];
            next_s.ptr = s.ptr + 8'h01;
        end

        // status: the read clears, then new events set, so set wins
        next_s.stat = stat_next(s.stat, ev_set, do_load && (s.ptr == `LMCIR_OFS_STAT));

        // supply-low flag
        if (s.cfg[`LMCIR_CFG_VAUTO] && (evt.movie_end || evt.pic_end)) begin
            next_s.low_vdd = 1'b0;
        end
        if (evt.low_vdd_det) begin
            next_s.low_vdd = 1'b1;
        end

        // lock holds until reset; nothing else clears it
        if (evt.data_wr) begin
            next_s.locked = 1'b1;
        end

        // interrupt pin, low active
        next_s.irq_low = irq_level(next_s.stat, next_s.mask,
                                   next_s.cfg[`LMCIR_CFG_VDIRECT], next_s.low_vdd);
    end

    // ************************************************************************
    // registers
    // ************************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= RST_S;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************************
    // outputs
    // ************************************************************************
    assign sda_out  = 1'b0;
    assign sda_oe_n = s.sda_oe_n;
    assign irq_out  = 1'b0;
    assign irq_oe_n = ~s.irq_low;

    always_comb begin
        cfg_out.open_led_disable = s.cfg[`LMCIR_CFG_OPENDIS];
        cfg_out.trim_enable      = s.cfg[`LMCIR_CFG_TRIM];
        cfg_out.layout           = s.cfg[`LMCIR_CFG_LAYOUT];
        cfg_out.layout_valid     = (s.cfg[`LMCIR_CFG_LAYOUT] != `LMCIR_LAYOUT_BAD)
                                 && (s.cfg[`LMCIR_CFG_LAYOUT] <= `LMCIR_LAYOUT_MAX);
        cfg_out.locked           = s.locked;
        cfg_out.low_vdd_flag     = s.low_vdd;
    end

endmodule
`default_nettype wire

// File: common/lmcir_regs.svh
/*
 * register offsets, field positions, reset values and fixed bus codes of the
 * configuration and interrupt-control register group.
 * assumes it is included by bare name from the design and the bench.
 */
`ifndef LMCIR_REGS_SVH
`define LMCIR_REGS_SVH

// ****************************************************************************
// register offsets (bus register pointer)
// ****************************************************************************
`define LMCIR_OFS_CFG      8'h06
`define LMCIR_OFS_MASK     8'h07
`define LMCIR_OFS_FRM      8'h08
`define LMCIR_OFS_STAT     8'h0E

// ****************************************************************************
// reset values
// ****************************************************************************
`define LMCIR_RST_CFG      8'h00
`define LMCIR_RST_MASK     8'h20
`define LMCIR_RST_FRM      6'h3F
`define LMCIR_RST_STAT     8'h20
`define LMCIR_STAT_CLR     8'h00

// ****************************************************************************
// configuration fields
// ****************************************************************************
`define LMCIR_CFG_VAUTO    7
`define LMCIR_CFG_VDIRECT  6
`define LMCIR_CFG_OPENDIS  5
`define LMCIR_CFG_TRIM     4
`define LMCIR_CFG_BCAST    3
`define LMCIR_CFG_LAYOUT   2:0
`define LMCIR_CFG_LOCKED   8'h17
`define LMCIR_LAYOUT_BAD   3'h0
`define LMCIR_LAYOUT_MAX   3'h6

// ****************************************************************************
// status and mask bit positions
// ****************************************************************************
`define LMCIR_EV_FRAME     7
`define LMCIR_EV_WDOG      6
`define LMCIR_EV_POR       5
`define LMCIR_EV_TEMP      4
`define LMCIR_EV_LOWV      3
`define LMCIR_EV_OPEN      2
`define LMCIR_EV_SHORT     1
`define LMCIR_EV_MOVIE     0

// ****************************************************************************
// bus addressing
// ****************************************************************************
`define LMCIR_BCAST_ADDR   7'h3F
`define LMCIR_BIT_LAST     4'h8

`endif

// File: common/lmcir_pkg.sv
/*
 * types of the configuration and interrupt-control register group.
 * assumes the constants header is included by the design file.
 */
package lmcir_pkg;

    typedef enum logic [2:0] {
        LMCIR_IDLE = 3'b000,
        LMCIR_ADDR = 3'b001,
        LMCIR_PTR  = 3'b010,
        LMCIR_WR   = 3'b011,
        LMCIR_RD   = 3'b100,
        LMCIR_ACKS = 3'b101,
        LMCIR_ACKM = 3'b110
    } lmcir_state_t;

    // events from the display engine, the test logic and the bus monitor
    typedef struct packed {
        logic       frame_done;
        logic       final_loop;
        logic [5:0] frame_num;
        logic       movie_end;
        logic       pic_end;
        logic       wdog;
        logic       overtemp;
        logic       low_vdd_det;
        logic       open_err;
        logic       short_err;
        logic       movie_fin;
        logic       data_wr;
    } lmcir_evt_t;

    // settings handed to the rest of the device
    typedef struct packed {
        logic       open_led_disable;
        logic       trim_enable;
        logic [2:0] layout;
        logic       layout_valid;
        logic       locked;
        logic       low_vdd_flag;
    } lmcir_cfg_t;

    typedef struct packed {
        lmcir_state_t st;
        lmcir_state_t ret;
        logic         scl_q;
        logic         sda_q;
        logic [7:0]   sh;
        logic [3:0]   cnt;
        logic         nack;
        logic [7:0]   ptr;
        logic         sda_oe_n;
        logic [7:0]   cfg;
        logic [7:0]   mask;
        logic [5:0]   frm;
        logic [7:0]   stat;
        logic         low_vdd;
        logic         locked;
        logic         irq_low;
    } lmcir_core_t;

endpackage

// File: tb/lmcir_top_properties.sv
/*
 * concurrent checks on the pins of the register group top.
 * assumes scl high and low phases of at least two clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module lmcir_top_properties (
    // clock and reset
    input wire logic                  ref_clk,
    input wire logic                  resetn,
    // watched pins
    input wire logic                  scl_in,
    input wire logic                  sda_oe_n,
    input wire logic                  irq_oe_n,
    input wire lmcir_pkg::lmcir_evt_t evt,
    input wire lmcir_pkg::lmcir_cfg_t cfg_out
);
    import lmcir_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic any_ev;
    assign any_ev = evt.frame_done | evt.wdog | evt.overtemp | evt.low_vdd_det
                  | evt.open_err | evt.short_err | evt.movie_fin;

    // ************************************************************
    // properties
    // ************************************************************
    sequence s_ack_edge;
        $fell(sda_oe_n);
    endsequence
    sequence s_lock_hold;
        cfg_out.locked && $stable(cfg_out.layout) && $stable(cfg_out.trim_enable);
    endsequence

    property p_layout_valid;
        cfg_out.layout_valid == (cfg_out.layout != 3'h0 && cfg_out.layout <= 3'h6);
    endproperty
    property p_lock_set;
        evt.data_wr |=> cfg_out.locked;
    endproperty
    property p_lock_keep;
        cfg_out.locked |=> s_lock_hold;
    endproperty
    property p_lowv_set;
        evt.low_vdd_det |=> cfg_out.low_vdd_flag;
    endproperty
    property p_lowv_clr;
        $fell(cfg_out.low_vdd_flag) |-> $past(evt.movie_end | evt.pic_end);
    endproperty
    property p_lowv_keep;
        cfg_out.low_vdd_flag && !(evt.movie_end | evt.pic_end) |=> cfg_out.low_vdd_flag;
    endproperty
    // a mask or config write lands on the ack edge and may assert the pin
    property p_irq_cause;
        $fell(irq_oe_n) |-> $past(any_ev) || $fell(sda_oe_n);
    endproperty
    property p_cfg_change;
        $changed({cfg_out.open_led_disable, cfg_out.trim_enable, cfg_out.layout})
            |-> s_ack_edge;
    endproperty
    property p_sda_low;
        $changed(sda_oe_n) |-> !scl_in;
    endproperty

    a_layout_valid: assert property (p_layout_valid) else $error("layout valid wrong");
    a_lock_set: assert property (p_lock_set) else $error("lock not set");
    a_lock_keep: assert property (p_lock_keep) else $error("locked field moved");
    a_lowv_set: assert property (p_lowv_set) else $error("supply flag not set");
    a_lowv_clr: assert property (p_lowv_clr) else $error("supply flag cleared");
    a_lowv_keep: assert property (p_lowv_keep) else $error("supply flag lost");
    a_irq_cause: assert property (p_irq_cause) else $error("pin without cause");
    a_cfg_change: assert property (p_cfg_change) else $error("cfg moved off ack");
    a_sda_low: assert property (p_sda_low) else $error("sda moved, scl high");
endmodule

bind lmcir_top lmcir_top_properties u_props (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .scl_in   (scl_in),
    .sda_oe_n (sda_oe_n),
    .irq_oe_n (irq_oe_n),
    .evt      (evt),
    .cfg_out  (cfg_out)
);

`default_nettype wire

// File: tb/lmcir_host.sv
/*
 * two-wire bus master model: start, stop, byte transfers, register access.
 * assumes a pulled-up sda wire resolved outside; data bit phases are four clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module lmcir_host (
    // clock
    input  wire logic ref_clk,
    // bus pins
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // data changes only while scl is low, never across the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b;
        tick(3);
        scl <= 1'b1;
        tick(2);
        #1 r = sda;
        tick(2);
        scl <= 1'b0;
        tick(1);
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic m,
                           output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(m, r);
        ack = !r;
    endtask

    task automatic start();
        sda_m <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(3);
        sda_m <= 1'b0;
        tick(3);
        scl <= 1'b0;
        tick(2);
    endtask

    task automatic stop();
        sda_m <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(3);
        sda_m <= 1'b1;
        tick(4);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                      output logic ok);
        logic [7:0] rx;
        logic       k1;
        logic       k2;
        logic       k3;
        start();
        byte_io({a, 1'b0}, 1'b1, rx, k1);
        byte_io(p, 1'b1, rx, k2);
        byte_io(d, 1'b1, rx, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask

    // single byte read ends with a master nack
    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
        logic [7:0] rx;
        logic       k;
        start();
        byte_io({a, 1'b0}, 1'b1, rx, k);
        byte_io(p, 1'b1, rx, k);
        start();
        byte_io({a, 1'b1}, 1'b1, rx, k);
        byte_io(8'hFF, 1'b1, d, k);
        stop();
    endtask
endmodule

`default_nettype wire

// File: tb/lmcir_top_tb.sv
/*
 * self-checking bench of the register group top.
 * assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lmcir_regs.svh"

module lmcir_top_tb;
    import lmcir_pkg::*;
    localparam logic [6:0] DEV = 7'h32;
    logic       ref_clk;
    logic       resetn;
    logic       scl;
    logic       sda_m;
    wire logic  sda;
    logic       sda_out;
    logic       sda_oe_n;
    logic       irq_out;
    logic       irq_oe_n;
    lmcir_evt_t evt;
    lmcir_cfg_t cfg_out;
    logic       ok;
    logic [7:0] d;
    int         error_cnt = 0;
    int         cmp_count = 0;

    assign sda = sda_m & sda_oe_n;

    lmcir_host u_host (.ref_clk(ref_clk), .scl(scl), .sda_m(sda_m), .sda(sda));

    lmcir_top uut (
        .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(3'h2),
        .irq_out(irq_out), .irq_oe_n(irq_oe_n), .evt(evt), .cfg_out(cfg_out)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] p, input logic [7:0] v);
        u_host.wr(DEV, p, v, ok);
        chk(ok, 8'h01);
    endtask

    task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
        u_host.rd(DEV, p, d);
        chk(d, exp);
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask

    function automatic lmcir_evt_t ev(input int i);
        lmcir_evt_t v;
        v = '0;
        case (i)
            7: begin
                v.frame_done = 1'b1;
                v.final_loop = 1'b1;
                v.frame_num = 6'h05;
            end
            6: v.wdog = 1'b1;
            4: v.overtemp = 1'b1;
            3: v.low_vdd_det = 1'b1;
            2: v.open_err = 1'b1;
            1: v.short_err = 1'b1;
            8: v.data_wr = 1'b1;
            9: v.movie_end = 1'b1;
            10: v.pic_end = 1'b1;
            default: v.movie_fin = 1'b1;
        endcase
        return v;
    endfunction

    task automatic pulse(input lmcir_evt_t v);
        @(posedge ref_clk);
        evt <= v;
        @(posedge ref_clk);
        evt <= '0;
        @(posedge ref_clk);
        #1;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_vals();
        chk(irq_oe_n, 8'h00);
        chk(sda_out, 8'h00);
        chk(irq_out, 8'h00);
        rchk(`LMCIR_OFS_CFG, 8'h00);
        rchk(`LMCIR_OFS_MASK, 8'h20);
        rchk(`LMCIR_OFS_FRM, 8'h3F);
        rchk(`LMCIR_OFS_STAT, 8'h20);
        chk(irq_oe_n, 8'h01);
    endtask

    task automatic t_mask();
        wreg(`LMCIR_OFS_MASK, 8'h80);
        pulse(ev(7));
        chk(irq_oe_n, 8'h01);
        wreg(`LMCIR_OFS_FRM, 8'h05);
        pulse(ev(7));
        chk(irq_oe_n, 8'h00);
        rchk(`LMCIR_OFS_STAT, 8'h80);
        for (int k = 0; k < 8; k++) begin
            if (k != 5) begin
                wreg(`LMCIR_OFS_MASK, 8'h00);
                pulse(ev(k));
                chk(irq_oe_n, 8'h01);
                wreg(`LMCIR_OFS_MASK, 8'h01 << k);
                chk(irq_oe_n, 8'h00);
                rchk(`LMCIR_OFS_STAT, 8'h01 << k);
                chk(irq_oe_n, 8'h01);
                pulse(ev(k));
                chk(irq_oe_n, 8'h00);
                rchk(`LMCIR_OFS_STAT, 8'h01 << k);
            end
        end
    endtask

    task automatic t_lock();
        wreg(`LMCIR_OFS_CFG, 8'h25);
        chk(cfg_out.open_led_disable, 8'h01);
        chk(cfg_out.layout, 8'h05);
        wreg(`LMCIR_OFS_CFG, 8'h00);
        chk(cfg_out.layout_valid, 8'h00);
        chk(cfg_out.open_led_disable, 8'h00);
        wreg(`LMCIR_OFS_CFG, 8'h06);
        chk(cfg_out.layout_valid, 8'h01);
        pulse(ev(8));
        chk(cfg_out.locked, 8'h01);
        wreg(`LMCIR_OFS_CFG, 8'h31);
        rchk(`LMCIR_OFS_CFG, 8'h26);
        chk(cfg_out.trim_enable, 8'h00);
        wreg(`LMCIR_OFS_FRM, 8'hFF);
        rchk(`LMCIR_OFS_FRM, 8'h3F);
        rchk(8'h0A, 8'h00);
        do_reset();
        chk(cfg_out.locked, 8'h00);
        wreg(`LMCIR_OFS_CFG, 8'h03);
        chk(cfg_out.layout, 8'h03);
    endtask

    task automatic t_direct();
        rchk(`LMCIR_OFS_STAT, 8'h20);
        wreg(`LMCIR_OFS_MASK, 8'h00);
        wreg(`LMCIR_OFS_CFG, 8'h40);
        pulse(ev(3));
        chk(irq_oe_n, 8'h00);
        pulse(ev(10));
        chk(cfg_out.low_vdd_flag, 8'h01);
        wreg(`LMCIR_OFS_CFG, 8'hC0);
        pulse(ev(9));
        chk(cfg_out.low_vdd_flag, 8'h00);
        chk(irq_oe_n, 8'h01);
        rchk(`LMCIR_OFS_STAT, 8'h08);
    endtask

    task automatic t_bcast();
        u_host.wr(`LMCIR_BCAST_ADDR, `LMCIR_OFS_MASK, 8'h11, ok);
        chk(ok, 8'h00);
        wreg(`LMCIR_OFS_CFG, 8'h08);
        u_host.wr(`LMCIR_BCAST_ADDR, `LMCIR_OFS_MASK, 8'h11, ok);
        chk(ok, 8'h01);
        rchk(`LMCIR_OFS_MASK, 8'h11);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        resetn = 1'b0;
        evt = '0;
        do_reset();
        t_reset_vals();
        t_mask();
        t_lock();
        t_direct();
        t_bcast();
        conclude();
    end
endmodule

`default_nettype wire
